// File: design/serial_channel_pkg.sv
// Package with register map, field positions, reset values and carrier types.
package serial_channel_pkg;

	// Register word indices (printed values are not all multiples of four; byte address is index * 4).
	localparam logic [11:0] IDX_CTRL1_CH0   = 12'h24d;
	localparam logic [11:0] IDX_CTRL1_CH1   = 12'h25d;
	localparam logic [11:0] IDX_CTRL1_CH2   = 12'h26d;
	localparam logic [11:0] IDX_SHARED      = 12'h27d;
	localparam logic [11:0] IDX_MODE_CH0    = 12'h248;
	localparam logic [11:0] IDX_MODE_CH1    = 12'h258;
	localparam logic [11:0] IDX_MODE_CH2    = 12'h268;
	localparam logic [11:0] IDX_CTRL0_CH0   = 12'h24c;
	localparam logic [11:0] IDX_CTRL0_CH1   = 12'h25c;
	localparam logic [11:0] IDX_CTRL0_CH2   = 12'h26c;
	localparam logic [11:0] IDX_ENGINE      = 12'h280;
	localparam logic [11:0] IDX_PCLK        = 12'h281;

	// Control-1 field positions.
	localparam int BIT_TX_ALLOW     = 0;
	localparam int BIT_TX_VACANT    = 1;
	localparam int BIT_RX_ALLOW     = 2;
	localparam int BIT_RX_LOADED    = 3;
	localparam int BIT_IRQ_SRC2     = 4;
	localparam int BIT_CONT_RX2     = 5;
	localparam int BIT_INVERT       = 6;
	localparam int BIT_ERR_ALLOW    = 7;

	// Shared control field positions.
	localparam int BIT_CH0_IRQ_SRC  = 0;
	localparam int BIT_CH1_IRQ_SRC  = 1;
	localparam int BIT_CH0_CONT_RX  = 2;
	localparam int BIT_CH1_CONT_RX  = 3;
	localparam int BIT_CLK_ROUTE    = 4;
	localparam int BIT_MULTIPIN     = 5;
	localparam int BIT_FLOW_SPLIT   = 6;

	// Control-0 field positions.
	localparam int BIT_CNT_LO       = 0;
	localparam int BIT_CNT_HI       = 1;
	localparam int BIT_TX_SHIFT_MT  = 3;
	localparam int BIT_OPEN_DRAIN   = 5;
	localparam int BIT_MSB_FIRST    = 7;

	// Reset values.
	localparam logic [7:0] RST_CTRL1  = 8'h02;
	localparam logic [7:0] RST_CTRL0  = 8'h08;
	localparam logic [7:0] RST_ZERO   = 8'h00;
	localparam logic [7:0] CTRL1_01_RMASK = 8'hcf;
	localparam logic [7:0] SHARED_RMASK   = 8'h7f;
	localparam logic [7:0] CTRL0_RW_MASK  = 8'hb7;

	// Mode field codes.
	typedef enum logic [2:0] {
		MODE_OFF     = 3'h0,
		MODE_SYNC    = 3'h1,
		MODE_I2C     = 3'h2,
		MODE_ASYNC7  = 3'h4,
		MODE_ASYNC8  = 3'h5,
		MODE_ASYNC9  = 3'h6
	} serial_mode_field_t;

	// Per-channel control bundle handed to the shift engines.
	typedef struct packed {
		logic txAllow;
		logic rxAllow;
		logic dataInvert;
		logic msbFirst;
		logic errOutAllow;
		logic continuousRx;
		logic txPinOpenDrain;
		logic flowUsable;
		logic [1:0] countSource;
		logic modeLegal;
	} chan_ctrl_t;

	// Per-channel engine status bundle.
	typedef struct packed {
		logic txBufFull;
		logic txShiftBusy;
		logic rxBufFull;
	} chan_stat_t;

endpackage : serial_channel_pkg

// File: design/edge_pulse.sv
// Rising-edge pulse generator for one condition, used per channel for transmit interrupts.
`timescale 1ns/1ps
module edge_pulse (
	input  wire logic mclk,   // System clock.
	input  wire logic srst,   // Synchronous reset, active high.
	input  wire logic level,  // Condition level, same clock domain.
	output logic      pulse   // One-cycle pulse on rising level.
);
	logic levelQ;

	// The history starts high so a condition already true at reset gives no pulse.
	always_ff @(posedge mclk) begin
		if (srst) begin
			levelQ <= 1'b1;
			pulse  <= 1'b0;
		end else begin
			levelQ <= level;
			pulse  <= level & ~levelQ;
		end
	end
endmodule : edge_pulse

// File: design/serial_channel_control.sv
// Control and status registers for three serial channels behind a Wishbone slave.
`timescale 1ns/1ps
// What the document requires of this block and its software
// RULE1: Channel 2 data and clock always open-drain; only txPinOpenDrain is forced, 0 until the first edge after reset.
// RULE2: Bit order honoured only in sync/async8.
// RULE3: Software sets bit order per mode.
// RULE4: Channel 1 flow control needs both bits zero.
// RULE5: Software rewrites divisor after source change.
// RULE6: Transmit enable gates transmission.
// RULE7: Transmit buffer vacant flag, one after reset.
// RULE8: Receive enable gates reception.
// RULE9: Channel 2 receive flag one when loaded.
// RULE10: Channels 0/1 receive flag inverted polarity.
// RULE11: Interrupt source: buffer empty or shift empty.
// RULE12: Continuous receive mode enable per channel.
// RULE13: Data inversion only sync, async7, async8.
// RULE14: Error output enable gates error signal.
// RULE15: Route bit picks ordinary or alternate pin.
// RULE16: Multipin select enables multipin clock output.
// RULE17: Split bit separates channel 0 CTS/RTS.
// RULE18: Peripheral select picks undivided or halved clock.
// RULE19: Software makes CTS pins inputs first.
// RULE20: Unimplemented bits read undefined, write zero.
// RULE21: Shift empty flag tracks transmit register.
// RULE22: Three-bit mode field, other codes forbidden.
// RULE23: Transmit interrupt pulses on condition rising.
module serial_channel_control
	import serial_channel_pkg::*;
(
	input  wire logic                              mclk,          // 40 MHz system clock.
	input  wire logic                              srst,          // Synchronous reset, high.
	input  wire logic                              wbCycI,        // Wishbone cycle.
	input  wire logic                              wbStbI,        // Wishbone strobe.
	input  wire logic                              wbWeI,         // Wishbone write enable.
	input  wire logic [13:0]                       wbAdrI,        // Wishbone byte address.
	input  wire logic [3:0]                        wbSelI,        // Wishbone byte selects.
	input  wire logic [31:0]                       wbDatI,        // Wishbone write data.
	output logic      [31:0]                       wbDatO,        // Wishbone read data.
	output logic                                   wbAckO,        // Wishbone acknowledge.
	input  wire serial_channel_pkg::chan_stat_t [2:0] engStat,    // Engine status per channel.
	output serial_channel_pkg::chan_ctrl_t      [2:0] chanCtrl,   // Controls per channel.
	output logic      [2:0]                        txIrq,         // Transmit interrupt pulses.
	output logic                                   ch1ClkOrdinary, // Ch1 clock on ordinary pin.
	output logic                                   ch1ClkAlternate, // Ch1 clock on alternate pin.
	output logic                                   ch0CtsSplitPin, // Ch0 CTS from separate pin.
	output logic      [2:0]                        divByTwo       // Count source halved.
);
	import serial_channel_pkg::*;

	logic [2:0][7:0] ctrl1Q;          // Writable control-1 bits per channel.
	logic [2:0][7:0] ctrl0Q;          // Writable control-0 bits per channel.
	logic [2:0][2:0] modeQ;           // Mode field per channel.
	logic [7:0]      sharedQ;         // Shared control register.
	logic            pclkSelQ;        // Peripheral clock select.
	logic [2:0][2:0] statQ;           // Synchronous copy of engine status.
	logic [2:0]      irqCond;         // Selected interrupt condition per channel.
	logic [2:0]      irqPulse;        // Edge pulses per channel.
	logic            hit;             // Request addressed to a mapped register.
	logic [7:0]      rdByte;          // Selected read byte.
	logic [11:0]     wordIdx;         // Register index from byte address.

	// Index is the byte address divided by four.
	assign wordIdx = wbAdrI[13:2];

	// Returns high when a mode code is one of the documented codes.
	function automatic logic modeIsLegal(input logic [2:0] m);
		unique case (m)
			MODE_OFF, MODE_SYNC, MODE_I2C, MODE_ASYNC7, MODE_ASYNC8, MODE_ASYNC9: begin
				modeIsLegal = 1'b1;
			end
			default: begin
				modeIsLegal = 1'b0;
			end
		endcase
	endfunction : modeIsLegal

	// Address decode for the read data path; the write path decodes wordIdx on its own.
	always_comb begin
		hit = 1'b1;
		unique case (wordIdx)
			IDX_CTRL1_CH0, IDX_CTRL1_CH1, IDX_CTRL1_CH2, IDX_SHARED,
			IDX_MODE_CH0, IDX_MODE_CH1, IDX_MODE_CH2,
			IDX_CTRL0_CH0, IDX_CTRL0_CH1, IDX_CTRL0_CH2, IDX_PCLK: begin
				hit = 1'b1;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// Status is registered so the flags are stable for a whole bus cycle.
	always_ff @(posedge mclk) begin
		if (srst) begin
			statQ <= '0;
		end else begin
			for (int c = 0; c < 3; c++) begin
				statQ[c] <= engStat[c];
			end
		end
	end

	// Register writes land only in the low byte lane, at the edge where the master sees ack.
	// Waiting for ack keeps a write from landing before the master knows it was taken.
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl1Q   <= {RST_CTRL1, RST_CTRL1, RST_CTRL1};
			ctrl0Q   <= {RST_CTRL0, RST_CTRL0, RST_CTRL0};
			modeQ    <= '0;
			sharedQ  <= RST_ZERO;
			pclkSelQ <= 1'b0;
		end else if (wbCycI && wbStbI && wbWeI && wbAckO && wbSelI[0]) begin
			unique case (wordIdx)
				IDX_CTRL1_CH0: begin
					// RULE20 write zero.
					ctrl1Q[0] <= wbDatI[7:0] & CTRL1_01_RMASK;
				end
				IDX_CTRL1_CH1: begin
					ctrl1Q[1] <= wbDatI[7:0] & CTRL1_01_RMASK;
				end
				IDX_CTRL1_CH2: begin
					ctrl1Q[2] <= wbDatI[7:0];
				end
				IDX_SHARED: begin
					sharedQ <= wbDatI[7:0] & SHARED_RMASK;
				end
				IDX_MODE_CH0: begin
					modeQ[0] <= wbDatI[2:0];
				end
				IDX_MODE_CH1: begin
					modeQ[1] <= wbDatI[2:0];
				end
				IDX_MODE_CH2: begin
					modeQ[2] <= wbDatI[2:0];
				end
				IDX_CTRL0_CH0: begin
					ctrl0Q[0] <= wbDatI[7:0];
				end
				IDX_CTRL0_CH1: begin
					ctrl0Q[1] <= wbDatI[7:0];
				end
				IDX_CTRL0_CH2: begin
					ctrl0Q[2] <= wbDatI[7:0];
				end
				IDX_PCLK: begin
					pclkSelQ <= wbDatI[0];
				end
				default: begin
				end
			endcase
		end
	end

	// Read byte assembly; status flags come from the engines, not the stored bits.
	always_comb begin
		rdByte = 8'h00;
		unique case (wordIdx)
			IDX_CTRL1_CH0, IDX_CTRL1_CH1: begin
				for (int c = 0; c < 2; c++) begin
					if (wordIdx == (c == 0 ? IDX_CTRL1_CH0 : IDX_CTRL1_CH1)) begin
						rdByte = ctrl1Q[c] & CTRL1_01_RMASK;
						// RULE7 vacant flag.
						rdByte[BIT_TX_VACANT] = ~statQ[c][2];
						// RULE10 inverted receive flag.
						rdByte[BIT_RX_LOADED] = ~statQ[c][0];
					end
				end
			end
			IDX_CTRL1_CH2: begin
				rdByte = ctrl1Q[2];
				rdByte[BIT_TX_VACANT] = ~statQ[2][2];
				// RULE9 receive flag.
				rdByte[BIT_RX_LOADED] = statQ[2][0];
			end
			IDX_SHARED: begin
				rdByte = sharedQ;
			end
			IDX_MODE_CH0: begin
				rdByte = {5'h00, modeQ[0]};
			end
			IDX_MODE_CH1: begin
				rdByte = {5'h00, modeQ[1]};
			end
			IDX_MODE_CH2: begin
				rdByte = {5'h00, modeQ[2]};
			end
			IDX_CTRL0_CH0, IDX_CTRL0_CH1, IDX_CTRL0_CH2: begin
				for (int c = 0; c < 3; c++) begin
					if (wordIdx == (c == 0 ? IDX_CTRL0_CH0 :
							(c == 1 ? IDX_CTRL0_CH1 : IDX_CTRL0_CH2))) begin
						rdByte = ctrl0Q[c] & CTRL0_RW_MASK;
						// RULE21 shift empty flag.
						rdByte[BIT_TX_SHIFT_MT] = ~statQ[c][1];
						if (c == 2) begin
							rdByte[BIT_OPEN_DRAIN] = 1'b0;
						end
					end
				end
			end
			IDX_PCLK: begin
				rdByte = {7'h00, pclkSelQ};
			end
			default: begin
				rdByte = 8'h00;
			end
		endcase
	end

	// Single-wait-state slave: ack one cycle after request, dropped the next cycle.
	always_ff @(posedge mclk) begin
		if (srst) begin
			wbAckO <= 1'b0;
			wbDatO <= '0;
		end else begin
			wbAckO <= wbCycI && wbStbI && !wbAckO;
			wbDatO <= (wbCycI && wbStbI && !wbAckO && !wbWeI && hit) ? {24'h000000, rdByte} : '0;
		end
	end

	// Interrupt condition selection per channel.
	generate
		for (genvar c = 0; c < 3; c++) begin : g_irq
			logic srcSel;
			if (c == 2) begin : g_src2
				assign srcSel = ctrl1Q[2][BIT_IRQ_SRC2];
			end else begin : g_src01
				assign srcSel = sharedQ[c == 0 ? BIT_CH0_IRQ_SRC : BIT_CH1_IRQ_SRC];
			end
			// RULE11 source select.
			assign irqCond[c] = srcSel ? (~statQ[c][1] & ~statQ[c][2]) : ~statQ[c][2];
			// RULE23 edge pulse.
			edge_pulse u_edge (
				.mclk  (mclk),
				.srst  (srst),
				.level (irqCond[c]),
				.pulse (irqPulse[c])
			);
		end
	endgenerate

	// Per-channel control outputs, registered.
	always_ff @(posedge mclk) begin
		if (srst) begin
			chanCtrl <= '0;
			txIrq    <= '0;
		end else begin
			txIrq <= irqPulse;
			for (int c = 0; c < 3; c++) begin
				// RULE22 legal mode.
				chanCtrl[c].modeLegal <= modeIsLegal(modeQ[c]);
				// RULE6 transmit gate.
				chanCtrl[c].txAllow <= ctrl1Q[c][BIT_TX_ALLOW];
				// RULE8 receive gate.
				chanCtrl[c].rxAllow <= ctrl1Q[c][BIT_RX_ALLOW];
				// RULE14 error output gate.
				chanCtrl[c].errOutAllow <= ctrl1Q[c][BIT_ERR_ALLOW];
				// RULE13 inversion mode gate.
				chanCtrl[c].dataInvert <= ctrl1Q[c][BIT_INVERT] &&
					(modeQ[c] == MODE_SYNC || modeQ[c] == MODE_ASYNC7 ||
					modeQ[c] == MODE_ASYNC8);
				// RULE2 bit order gate.
				chanCtrl[c].msbFirst <= ctrl0Q[c][BIT_MSB_FIRST] &&
					(modeQ[c] == MODE_SYNC || modeQ[c] == MODE_ASYNC8);
				chanCtrl[c].countSource <= {ctrl0Q[c][BIT_CNT_HI], ctrl0Q[c][BIT_CNT_LO]};
				chanCtrl[c].flowUsable <= 1'b1;
			end
			// RULE12 continuous receive.
			chanCtrl[0].continuousRx <= sharedQ[BIT_CH0_CONT_RX];
			chanCtrl[1].continuousRx <= sharedQ[BIT_CH1_CONT_RX];
			chanCtrl[2].continuousRx <= ctrl1Q[2][BIT_CONT_RX2];
			chanCtrl[0].txPinOpenDrain <= ctrl0Q[0][BIT_OPEN_DRAIN];
			chanCtrl[1].txPinOpenDrain <= ctrl0Q[1][BIT_OPEN_DRAIN];
			// RULE1 forced open drain.
			chanCtrl[2].txPinOpenDrain <= 1'b1;
			// RULE4 channel 1 flow.
			chanCtrl[1].flowUsable <= ~sharedQ[BIT_MULTIPIN] & ~sharedQ[BIT_FLOW_SPLIT];
		end
	end

	// Pin routing outputs for the shared control register, and divByTwo from pclkSelQ and control-0.
	always_ff @(posedge mclk) begin
		if (srst) begin
			ch1ClkOrdinary  <= 1'b1;
			ch1ClkAlternate <= 1'b0;
			ch0CtsSplitPin  <= 1'b0;
			divByTwo        <= '0;
		end else begin
			// RULE16 multipin select.
			// RULE15 route select.
			ch1ClkOrdinary  <= ~sharedQ[BIT_MULTIPIN] | ~sharedQ[BIT_CLK_ROUTE];
			ch1ClkAlternate <= sharedQ[BIT_MULTIPIN] & sharedQ[BIT_CLK_ROUTE];
			// RULE17 flow split.
			ch0CtsSplitPin  <= sharedQ[BIT_FLOW_SPLIT];
			// RULE18 halved clock choice.
			for (int c = 0; c < 3; c++) begin
				divByTwo[c] <= pclkSelQ == 1'b0 &&
					ctrl0Q[c][BIT_CNT_HI] == 1'b0 && ctrl0Q[c][BIT_CNT_LO] == 1'b0;
			end
		end
	end

endmodule : serial_channel_control

// File: sim/serial_engine_model.sv
// Behavioural model of the shift engines that report buffer status to the block.
`timescale 1ns/1ps
module serial_engine_model
	import serial_channel_pkg::*;
#(
	parameter int SHIFT = 20	// Cycles one frame keeps the shift register busy.
)(
	input  wire logic                                  mclk,	// Clock.
	input  wire logic                                  srst,	// Reset, high.
	input  wire serial_channel_pkg::chan_ctrl_t [2:0] ctrl,	// Controls.
	input  wire logic [8:0]                            ev,	// Load, arrive, take.
	output serial_channel_pkg::chan_stat_t [2:0]       stat	// Status.
);
	int cnt[3];

	// Buffer hand-off, frame timing and receive landing per channel.
	always_ff @(posedge mclk) begin
		for (int i = 0; i < 3; i++) begin
			if (srst) begin
				stat[i] <= '0;
				cnt[i] <= 0;
			end else begin
				// frames start only while sending is allowed.
				if (ev[i]) begin
					stat[i].txBufFull <= 1'b1;
				end else if (stat[i].txBufFull && cnt[i] == 0 && ctrl[i].txAllow) begin
					stat[i].txBufFull <= 1'b0;
					stat[i].txShiftBusy <= 1'b1;
					cnt[i] <= SHIFT;
				end else if (cnt[i] > 0) begin
					cnt[i] <= cnt[i] - 1;
					stat[i].txShiftBusy <= cnt[i] > 1;
				end
				// frames land only while reception is allowed.
				if (ev[3 + i] && ctrl[i].rxAllow) begin
					stat[i].rxBufFull <= 1'b1;
				end else if (ev[6 + i]) begin
					stat[i].rxBufFull <= 1'b0;
				end
			end
		end
	end
endmodule : serial_engine_model

// File: sim/serial_channel_control_monitor.sv
// Port checker for the serial channel control block.
`timescale 1ns/1ps
module serial_channel_monitor
	import serial_channel_pkg::*;
(
	input wire logic                                  mclk,	// Clock.
	input wire logic                                  srst,	// Reset.
	input wire logic                                  wbCycI,	// Cycle.
	input wire logic                                  wbStbI,	// Strobe.
	input wire logic [31:0]                           wbDatO,	// Read data.
	input wire logic                                  wbAckO,	// Acknowledge.
	input wire serial_channel_pkg::chan_stat_t [2:0] engStat,	// Status.
	input wire serial_channel_pkg::chan_ctrl_t [2:0] chanCtrl,	// Controls.
	input wire logic [2:0]                            txIrq,	// Pulses.
	input wire logic                                  ch1ClkOrdinary,	// Pin.
	input wire logic                                  ch1ClkAlternate,	// Pin.
	input wire logic                                  ch0CtsSplitPin	// Pin.
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);

	// A taken request and its single-cycle answer.
	sequence req_s;
		wbCycI && wbStbI && !wbAckO;
	endsequence
	sequence ack_s;
		wbAckO ##1 !wbAckO;
	endsequence

	chk_ack_answer: assert property (req_s |=> ack_s)
		else $error("ack not one cycle after request");
	chk_data_idle: assert property (!wbAckO |-> wbDatO == 32'h0)
		else $error("read data outside ack");
	chk_data_width: assert property (wbAckO |-> wbDatO[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_ch2_drain: assert property (
		!$past(srst) && !$past(srst, 2) |-> chanCtrl[2].txPinOpenDrain)
		else $error("channel 2 not open drain");
	chk_irq_once: assert property (|txIrq |=> (txIrq & $past(txIrq)) == 3'h0)
		else $error("interrupt longer than a pulse");
	chk_irq_cause: assert property (
		txIrq[2] |-> !engStat[2].txBufFull && !$past(engStat[2].txBufFull, 2))
		else $error("interrupt with buffer full");
	chk_clk_pin: assert property ($onehot({ch1ClkOrdinary, ch1ClkAlternate}))
		else $error("clock pin routing not one hot");
	chk_flow_split: assert property (
		ch0CtsSplitPin || ch1ClkAlternate |-> !chanCtrl[1].flowUsable)
		else $error("channel 1 flow control usable");
endmodule : serial_channel_monitor

bind serial_channel_control serial_channel_monitor i_serial_channel_monitor (
	.mclk(mclk), .srst(srst), .wbCycI(wbCycI), .wbStbI(wbStbI), .wbDatO(wbDatO),
	.wbAckO(wbAckO), .engStat(engStat), .chanCtrl(chanCtrl), .txIrq(txIrq),
	.ch1ClkOrdinary(ch1ClkOrdinary), .ch1ClkAlternate(ch1ClkAlternate),
	.ch0CtsSplitPin(ch0CtsSplitPin));

// File: sim/testbench.sv
// Self-checking bench for the serial channel control block.
`timescale 1ns/1ps
module testbench;
	import serial_channel_pkg::*;
	logic mclk = 0, srst = 1, cyc = 0, stb = 0, we = 0, ack, ord, alt, split;
	logic [13:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] dat = '0, datO, rdat;
	logic [8:0] ev = '0;
	logic [2:0] irq, div;
	logic [7:0] w;
	chan_stat_t [2:0] stat;
	chan_ctrl_t [2:0] ctl;
	int fails = 0, comparisons = 0, cycles = 0, irqCnt = 0, k;
	int shadow[int];
	int txB[3], shB[3], rxB[3];

	serial_channel_control i_serial_channel_control (.mclk(mclk), .srst(srst),
		.wbCycI(cyc), .wbStbI(stb), .wbWeI(we), .wbAdrI(adr), .wbSelI(sel),
		.wbDatI(dat), .wbDatO(datO), .wbAckO(ack), .engStat(stat), .chanCtrl(ctl),
		.txIrq(irq), .ch1ClkOrdinary(ord), .ch1ClkAlternate(alt),
		.ch0CtsSplitPin(split), .divByTwo(div));
	serial_engine_model i_serial_engine_model (.mclk(mclk), .srst(srst),
		.ctrl(ctl), .ev(ev), .stat(stat));

	// Free-running 40 MHz clock.
	initial begin
		forever #12.5 mclk = ~mclk;
	end

	// Cycle ceiling and channel 2 pulse count; non-blocking so readers never race it.
	always @(posedge mclk) begin
		cycles++;
		irqCnt <= irqCnt + int'(irq[2] === 1'b1);
		if (cycles == 20000) begin
			fails++;
			close_out();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// One classic cycle; holds everything until ack is sampled high.
	task automatic bus(input logic [11:0] idx, input logic wr, input logic [7:0] d);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		sel <= 4'h1;
		adr <= {idx, 2'b00};
		dat <= {24'h0, d};
		do begin
			@(posedge mclk);
		end while (ack !== 1'b1);
		rdat = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (wr) shadow[idx] = d;
	endtask : bus

	// Expected read value from stored writes and the engine state the bench set up.
	function automatic logic [7:0] model(input logic [11:0] idx);
		logic [7:0] s;
		int c;
		s = shadow.exists(idx) ? 8'(shadow[idx]) : 8'h0;
		c = int'(idx[5:4]);
		case (idx)
			IDX_CTRL1_CH0, IDX_CTRL1_CH1, IDX_CTRL1_CH2: return (s & (c == 2 ? 8'hf5 : 8'hc5))
				| {4'h0, (c == 2) == (rxB[c] != 0), 1'b0, txB[c] == 0, 1'b0};
			IDX_CTRL0_CH0, IDX_CTRL0_CH2: return (s & (c == 2 ? 8'h97 : 8'hb7))
				| {4'h0, shB[c] == 0, 3'h0};
			IDX_SHARED: return s & 8'h7f;
			default: return 8'h0;
		endcase
	endfunction : model

	task automatic rd(input logic [11:0] idx);
		bus(idx, 1'b0, 8'h0);
		check($sformatf("reg %h", idx), rdat, {24'h0, model(idx)});
	endtask : rd

	// Pulse one engine event line for a single cycle.
	task automatic ping(input int b);
		@(posedge mclk);
		ev <= 9'(1 << b);
		@(posedge mclk);
		ev <= '0;
		repeat (3) @(posedge mclk);
	endtask : ping

	task automatic close_out();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out

	// Main sequence: reset contents, random writes, routing, modes, interrupts, receive.
	initial begin
		void'($urandom(32'h6e34cfd1));
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		rd(IDX_CTRL1_CH0);
		rd(IDX_CTRL1_CH2);
		rd(IDX_CTRL0_CH2);
		rd(12'h3ff);
		for (k = 0; k < 12; k++) begin
			w = 8'($urandom);
			bus(IDX_CTRL1_CH0 + 12'(k % 3 * 16), 1'b1, w);
			rd(IDX_CTRL1_CH0 + 12'(k % 3 * 16));
			check("txAllow", ctl[k % 3].txAllow, w[0]);
			check("rxAllow", ctl[k % 3].rxAllow, w[2]);
			check("errOut", ctl[k % 3].errOutAllow, w[7]);
		end
		for (k = 0; k < 8; k++) begin
			w = {1'b0, 3'(k), 4'($urandom)};
			bus(IDX_SHARED, 1'b1, w);
			rd(IDX_SHARED);
			check("ordinary", ord, !(w[5] && w[4]));
			check("alternate", alt, w[5] && w[4]);
			// the partner keeps its CTS pins as inputs; the split only routes them.
			check("split", split, w[6]);
			check("flow1", ctl[1].flowUsable, !w[5] && !w[6]);
			check("cont0", ctl[0].continuousRx, w[2]);
		end
		bus(IDX_CTRL0_CH2, 1'b1, 8'h20);
		rd(IDX_CTRL0_CH2);
		check("drain2", ctl[2].txPinOpenDrain, 1'b1);
		for (k = 0; k < 8; k++) begin
			// bit order kept legal for each mode.
			bus(IDX_CTRL0_CH0, 1'b1, (k == 4 || k == 6) ? 8'h20 : 8'ha0);
			// inversion kept off in I2C and 9-bit modes.
			bus(IDX_CTRL1_CH0, 1'b1, (k == 2 || k == 6) ? 8'h00 : 8'h40);
			bus(IDX_MODE_CH0, 1'b1, 8'(k));
			repeat (3) @(posedge mclk);
			check("msb", ctl[0].msbFirst, k == 1 || k == 5);
			check("invert", ctl[0].dataInvert, k == 1 || k == 4 || k == 5);
			check("legal", ctl[0].modeLegal, k != 3 && k != 7);
		end
		// Count source 00 is halved while the peripheral select is low.
		check("div0", div[0], 1'b1);
		// the divisor lives in the baud generator; the source bits stay put here.
		bus(IDX_PCLK, 1'b1, 8'h01);
		repeat (2) @(posedge mclk);
		check("div1", div[0], 1'b0);
		bus(IDX_CTRL1_CH2, 1'b1, 8'h10);
		ping(2);
		txB[2] = 1;
		rd(IDX_CTRL1_CH2);
		k = irqCnt;
		bus(IDX_CTRL1_CH2, 1'b1, 8'h11);
		txB[2] = 0;
		shB[2] = 1;
		repeat (4) @(posedge mclk);
		rd(IDX_CTRL0_CH2);
		check("irqEarly", irqCnt - k, 0);
		repeat (30) @(posedge mclk);
		shB[2] = 0;
		rd(IDX_CTRL0_CH2);
		check("irqDone", irqCnt - k, 1);
		bus(IDX_CTRL1_CH2, 1'b1, 8'h01);
		k = irqCnt;
		ping(2);
		repeat (4) @(posedge mclk);
		check("irqEmpty", irqCnt - k, 1);
		repeat (30) @(posedge mclk);
		check("irqOnce", irqCnt - k, 1);
		bus(IDX_CTRL1_CH2, 1'b1, 8'h24);
		bus(IDX_CTRL1_CH0, 1'b1, 8'h04);
		check("cont2", ctl[2].continuousRx, 1'b1);
		ping(5);
		ping(3);
		rxB[0] = 1;
		rxB[2] = 1;
		rd(IDX_CTRL1_CH2);
		rd(IDX_CTRL1_CH0);
		ping(8);
		ping(6);
		rxB[0] = 0;
		rxB[2] = 0;
		rd(IDX_CTRL1_CH2);
		rd(IDX_CTRL1_CH0);
		close_out();
	end
endmodule : testbench
